//--- hdl/slm_lane_mapper.sv
// Lane mapper and test pattern source for an eight-lane serial output.
// Assumes a link layer that takes one octet per lane on lane_ready,
// and an Avalon-MM master for the control registers.
`timescale 1ns/1ps
`include "slm_consts.svh"

// Functional notes
// R01: Mode 12: one octet per lane, A0-A3, B0-B3
// R02: Mode 13: nine bits plus zero, five octets
// R03: Mode 14: 12-bit pad, lane pairs even/odd
// R04: Mode 15: lane k carries k and k+4
// R05: Sync header carries CRC-12 or FEC only
// R06: Alternate bank only with four lanes or fewer
// R07: Bank 0 lower lanes, 1 upper, one bank
// R08: Power-down pin or control disables drivers
// R09: Configuration kept across power-down
// R10: Receiver relinks and flushes after power-down
// R11: Channel pairs disabled; never all channels
// R12: PRBS bypasses transport and link layers
// R13: Five PRBS polynomials, two-tap XOR
// R14: Each lane's PRBS starts at unique phase
// R15: Clock pattern: eight ones, eight zeros
// R16: Ramp ignores samples, link layer stays on
// R17: Ramp starts after link ready
// R18: Ramp octets 0x00 to 0xFF, same all lanes
// R19: One pattern source; otherwise mapped samples
module slm_lane_mapper import slm_pkg::*; (
  input logic core_clk, // 125 MHz clock
  input logic reset_n, // Sync reset, low
  input logic [3:0] avs_address, // Byte address
  input logic avs_read, // Read strobe
  input logic avs_write, // Write strobe
  input logic [31:0] avs_writedata, // Write data
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  input logic smp_valid, // Sample word offered
  input slm_word_t smp_data, // Sixteen samples per channel
  output logic smp_ready, // Sample word taken
  input logic power_down_pin, // Power-down pin
  input logic link_ready, // Alignment or serializer init done
  input logic lane_ready, // Link takes octets
  output slm_lanes_t lane_data, // One octet per lane
  output logic lane_valid, // Octets valid
  output logic lane_bypass, // Send raw, no scramble or code
  output logic [7:0] lane_drv_en, // Lane driver enables
  output logic sh_fec // Sync header: 0 CRC-12, 1 FEC
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [`SLM_CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [1:0] channel_pair_enable_q, channel_pair_enable_d;
  logic wr_q, wr_d;
  logic [31:0] rd_q, rd_d;
  logic req, ack;
  logic [3:0] lane_map_mode;
  logic lane_bank_select, sgl, pd, four_lanes, alt;
  slm_src_t src_q, src_d;
  slm_frame_t sr_q, sr_d;
  logic [2:0] left_q, left_d;
  logic [7:0][30:0] prbs_q, prbs_d;
  logic ck_q, ck_d;
  logic [7:0] ramp_q, ramp_d;
  logic ramp_on_q, ramp_on_d;
  slm_lanes_t ld_q, ld_d;
  logic lv_q, lv_d, byp_q, byp_d, fec_q, fec_d;
  logic [7:0] en_q, en_d;
  logic f_valid, f_ready;
  slm_word_t f_word, w;
  slm_frame_t frm;
  logic adv;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Nine bits then one zero
  function automatic logic [9:0] p10(input slm_smp_t s);
    return {s, 1'b0};
  endfunction

  // Nine bits then three zeros
  function automatic logic [11:0] p12(input slm_smp_t s);
    return {s, 3'b000};
  endfunction

  // Frame length in octets for a map mode
  function automatic logic [2:0] flen(input logic [3:0] m);
    unique case (m)
      `SLM_MODE_12: return `SLM_FLEN_1;
      `SLM_MODE_13: return `SLM_FLEN_5;
      default: return `SLM_FLEN_3;
    endcase
  endfunction

  // Legal map mode check, used for control register writes only
  function automatic logic mode_ok(input logic [3:0] m);
    return m == `SLM_MODE_12 || m == `SLM_MODE_13 ||
           m == `SLM_MODE_14 || m == `SLM_MODE_15;
  endfunction

  // Eight PRBS bits, first bit sent in the octet MSB
  function automatic logic [38:0] prbs8(input logic [30:0] s,
                                        input logic [2:0] sel);
    logic [30:0] t;
    logic [7:0] o;
    logic nb;
    t = s;
    o = '0;
    for (int i = 0; i < 8; i++) begin
      unique case (sel)
        `SLM_PS_7: nb = t[5] ^ t[6];
        `SLM_PS_9: nb = t[4] ^ t[8];
        `SLM_PS_15: nb = t[13] ^ t[14];
        `SLM_PS_23: nb = t[17] ^ t[22];
        default: nb = t[27] ^ t[30];
      endcase
      t = {t[29:0], nb};
      o = {o[6:0], nb};
    end
    return {o, t};
  endfunction

  // ----------------------------------------
  // Register access
  // ----------------------------------------
  assign lane_map_mode = ctrl_q[`SLM_CF_MODE];
  assign lane_bank_select = ctrl_q[`SLM_CF_BANK];
  assign sgl = ctrl_q[`SLM_CF_SGL];
  assign req = avs_read | avs_write;
  assign ack = req & ~wr_q;

  // Decode, write, read data, waitrequest
  always_comb begin
    ctrl_d = ctrl_q;
    channel_pair_enable_d = channel_pair_enable_q;
    wr_d = wr_q ? ~req : 1'b1;
    rd_d = rd_q;
    if (avs_write && ack) begin
      unique case (avs_address)
        `SLM_OFS_CTRL: begin
          ctrl_d = avs_writedata[`SLM_CTRL_W-1:0];
          if (!mode_ok(avs_writedata[`SLM_CF_MODE])) begin
            ctrl_d[`SLM_CF_MODE] = lane_map_mode;
          end
        end
        `SLM_OFS_CHAN: begin
          if (avs_writedata[1:0] != `SLM_CHAN_NONE) begin // [R11]
            channel_pair_enable_d = avs_writedata[1:0];
          end
        end
        default: ;
      endcase
    end
    if (avs_read && wr_q) begin
      unique case (avs_address)
        `SLM_OFS_CTRL: rd_d = {{(32 - `SLM_CTRL_W){1'b0}}, ctrl_q};
        `SLM_OFS_CHAN: rd_d = {30'h0, channel_pair_enable_q};
        `SLM_OFS_STAT: rd_d = {28'h0, ramp_on_q, alt, four_lanes, pd};
        default: rd_d = 32'h0;
      endcase
    end
  end

  // Configuration has no tie to power-down, so it survives it
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ctrl_q <= `SLM_CTRL_RST;
      channel_pair_enable_q <= `SLM_CHAN_RST;
      wr_q <= 1'b1;
      rd_q <= 32'h0;
    end else begin
      ctrl_q <= ctrl_d; // [R09]
      channel_pair_enable_q <= channel_pair_enable_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  // ----------------------------------------
  // Sample FIFO
  // ----------------------------------------
  slm_fifo #(
    .W($bits(slm_word_t)),
    .D(`SLM_FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .in_valid(smp_valid),
    .in_data(smp_data),
    .in_ready(smp_ready),
    .out_valid(f_valid),
    .out_data(f_word),
    .out_ready(f_ready)
  );

  // ----------------------------------------
  // Lane usage, bank and power-down
  // ----------------------------------------
  assign pd = power_down_pin | ctrl_q[`SLM_CF_PD]; // [R08]
  assign four_lanes = sgl | (channel_pair_enable_q != `SLM_CHAN_RST) |
                      (lane_map_mode == `SLM_MODE_14);
  assign alt = four_lanes & lane_bank_select; // [R06]

  // ----------------------------------------
  // Frame builder
  // ----------------------------------------
  // Zero channels switched off, then place samples on lanes
  always_comb begin
    w = f_word;
    if (!channel_pair_enable_q[0]) begin
      w.a = '0;
    end
    if (!channel_pair_enable_q[1] || sgl) begin
      w.b = '0;
    end
    frm = '0;
    for (int k = 0; k < 4; k++) begin
      unique case (lane_map_mode)
        `SLM_MODE_12: begin
          frm[k] = {w.a[k][8:1], 32'h0}; // [R01]
          frm[k+4] = {w.b[k][8:1], 32'h0}; // [R01]
        end
        `SLM_MODE_13: begin
          frm[k] = {p10(w.a[k]), p10(w.a[k+4]),
                    p10(w.a[k+8]), p10(w.a[k+12])}; // [R02]
          frm[k+4] = {p10(w.b[k]), p10(w.b[k+4]),
                      p10(w.b[k+8]), p10(w.b[k+12])}; // [R02]
        end
        `SLM_MODE_14: begin
          frm[k] = (k < 2) ?
            {p12(w.a[k]), p12(w.a[k+2]), 16'h0} :
            {p12(w.b[k-2]), p12(w.b[k]), 16'h0}; // [R03]
        end
        default: begin
          frm[k] = {p12(w.a[k]), p12(w.a[k+4]), 16'h0}; // [R04]
          frm[k+4] = {p12(w.b[k]), p12(w.b[k+4]), 16'h0}; // [R04]
        end
      endcase
    end
  end

  // ----------------------------------------
  // Source select and lane stream
  // ----------------------------------------
  assign adv = lane_ready & ~pd;
  // Ramp discards samples; mapping takes one word per frame
  assign f_ready = (src_q == SLM_SRC_RAMP) |
                   (src_q == SLM_SRC_MAP && adv && left_q == '0); // [R16]

  always_comb begin
    unique case (ctrl_q[`SLM_CF_TEST]) // [R19]
      `SLM_TM_PRBS: src_d = SLM_SRC_PRBS;
      `SLM_TM_CLK: src_d = SLM_SRC_CLK;
      `SLM_TM_RAMP: src_d = SLM_SRC_RAMP;
      default: src_d = SLM_SRC_MAP;
    endcase
  end

  // Next lane octets for the selected source
  always_comb begin
    logic [38:0] pn;
    pn = '0;
    sr_d = sr_q;
    left_d = left_q;
    prbs_d = prbs_q;
    ck_d = ck_q;
    ramp_d = ramp_q;
    ramp_on_d = ramp_on_q & (src_q == SLM_SRC_RAMP) & ~pd;
    ld_d = ld_q;
    lv_d = 1'b0;
    byp_d = (src_q == SLM_SRC_PRBS) | (src_q == SLM_SRC_CLK); // [R12] [R15]
    fec_d = ctrl_q[`SLM_CF_FEC]; // [R05]
    en_d = pd ? 8'h00 : (!four_lanes ? 8'hFF :
           (alt ? 8'hF0 : 8'h0F)); // [R07] [R08]
    if (src_q != SLM_SRC_MAP) begin
      left_d = '0;
    end
    if (src_q != SLM_SRC_PRBS) begin
      for (int k = 0; k < 8; k++) begin
        prbs_d[k] = `SLM_PRBS_SEED ^ 31'(k); // [R14]
      end
    end
    if (src_q != SLM_SRC_RAMP) begin
      ramp_d = `SLM_RAMP_RST;
    end
    if (adv) begin
      unique case (src_q)
        SLM_SRC_PRBS: begin
          for (int k = 0; k < 8; k++) begin
            pn = prbs8(prbs_q[k], ctrl_q[`SLM_CF_PRBS]); // [R13]
            ld_d[k] = pn[38:31];
            prbs_d[k] = pn[30:0];
          end
          lv_d = 1'b1;
        end
        SLM_SRC_CLK: begin
          ld_d = {8{ck_q ? `SLM_CLK_LO : `SLM_CLK_HI}}; // [R15]
          ck_d = ~ck_q;
          lv_d = 1'b1;
        end
        SLM_SRC_RAMP: begin
          if (link_ready || ramp_on_q) begin // [R17]
            ramp_on_d = 1'b1;
            ld_d = {8{ramp_q}}; // [R18]
            ramp_d = ramp_q + 8'h01; // [R18]
            lv_d = 1'b1;
          end
        end
        default: begin
          if (left_q != '0) begin
            for (int k = 0; k < 8; k++) begin
              ld_d[k] = sr_q[k][39:32];
              sr_d[k] = {sr_q[k][31:0], 8'h00};
            end
            left_d = left_q - 3'h1;
            lv_d = 1'b1;
          end else if (f_valid) begin
            for (int k = 0; k < 8; k++) begin
              ld_d[k] = frm[k][39:32];
              sr_d[k] = {frm[k][31:0], 8'h00};
            end
            left_d = flen(lane_map_mode) - 3'h1;
            lv_d = 1'b1;
          end
        end
      endcase
    end
    // Bank 1 four-lane content moves up with each new octet set, so stalls hold
    if (alt && lv_d) begin
      ld_d[7:4] = ld_d[3:0]; // [R07]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      src_q <= SLM_SRC_MAP;
      sr_q <= '0;
      left_q <= '0;
      prbs_q <= '0;
      ck_q <= 1'b0;
      ramp_q <= `SLM_RAMP_RST;
      ramp_on_q <= 1'b0;
      ld_q <= '0;
      lv_q <= 1'b0;
      byp_q <= 1'b0;
      fec_q <= 1'b0;
      en_q <= 8'h00;
    end else begin
      src_q <= src_d;
      sr_q <= sr_d;
      left_q <= left_d;
      prbs_q <= prbs_d;
      ck_q <= ck_d;
      ramp_q <= ramp_d;
      ramp_on_q <= ramp_on_d;
      ld_q <= ld_d;
      lv_q <= lv_d;
      byp_q <= byp_d;
      fec_q <= fec_d;
      en_q <= en_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign avs_readdata = rd_q;
  assign avs_waitrequest = wr_q;
  assign lane_data = ld_q;
  assign lane_valid = lv_q;
  assign lane_bypass = byp_q;
  assign lane_drv_en = en_q;
  assign sh_fec = fec_q;
endmodule // slm_lane_mapper

//--- hdl/slm_consts.svh
// Constants for the serial lane mapper: register map, fields, codes.
// Assumes inclusion by bare name from the design files.
`ifndef SLM_CONSTS_SVH
`define SLM_CONSTS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SLM_OFS_CTRL 4'h0
`define SLM_OFS_CHAN 4'h4
`define SLM_OFS_STAT 4'h8
// ----------------------------------------
// Control fields and reset values
// ----------------------------------------
`define SLM_CF_MODE 3:0
`define SLM_CF_BANK 4
`define SLM_CF_PD 5
`define SLM_CF_TEST 7:6
`define SLM_CF_PRBS 10:8
`define SLM_CF_FEC 11
`define SLM_CF_SGL 12
`define SLM_CTRL_W 13
`define SLM_CTRL_RST 13'h000C
`define SLM_CHAN_RST 2'h3
`define SLM_CHAN_NONE 2'h0
// ----------------------------------------
// Lane map modes and frame lengths in octets
// ----------------------------------------
`define SLM_MODE_12 4'hC
`define SLM_MODE_13 4'hD
`define SLM_MODE_14 4'hE
`define SLM_MODE_15 4'hF
`define SLM_FLEN_1 3'h1
`define SLM_FLEN_3 3'h3
`define SLM_FLEN_5 3'h5
// ----------------------------------------
// Test modes and sequence selects
// ----------------------------------------
`define SLM_TM_NORM 2'h0
`define SLM_TM_PRBS 2'h1
`define SLM_TM_CLK 2'h2
`define SLM_TM_RAMP 2'h3
`define SLM_PS_7 3'h0
`define SLM_PS_9 3'h1
`define SLM_PS_15 3'h2
`define SLM_PS_23 3'h3
`define SLM_PS_31 3'h4
`define SLM_PRBS_SEED 31'h5A5A5A5F
`define SLM_RAMP_RST 8'h00
`define SLM_CLK_HI 8'hFF
`define SLM_CLK_LO 8'h00
`define SLM_FIFO_DEPTH 8
`endif

//--- hdl/slm_pkg.sv
// Types shared by the serial lane mapper and its tests.
// Assumes nothing beyond a SystemVerilog compiler.
package slm_pkg;
  // ----------------------------------------
  // Sample carriers
  // ----------------------------------------
  typedef logic [8:0] slm_smp_t;
  typedef struct packed {
    slm_smp_t [15:0] b;
    slm_smp_t [15:0] a;
  } slm_word_t;
  typedef logic [7:0][7:0] slm_lanes_t;
  typedef logic [7:0][39:0] slm_frame_t;
  // ----------------------------------------
  // Lane source select, one-hot
  // ----------------------------------------
  typedef enum logic [3:0] {
    SLM_SRC_MAP = 4'b0001,
    SLM_SRC_PRBS = 4'b0010,
    SLM_SRC_CLK = 4'b0100,
    SLM_SRC_RAMP = 4'b1000
  } slm_src_t;
endpackage

//--- hdl/slm_fifo.sv
// Sample FIFO with registered read data and valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module slm_fifo #(
  parameter int W = 288,
  parameter int D = 8
) (
  input logic core_clk, // Clock
  input logic reset_n, // Sync reset, low
  input logic in_valid, // Write request
  input logic [W-1:0] in_data, // Write word
  output logic in_ready, // Space free
  output logic out_valid, // Read word present
  output logic [W-1:0] out_data, // Read word
  input logic out_ready // Read accept
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic ov_q, ov_d, ir_q, ir_d;
  logic [W-1:0] od_q, od_d;
  logic push, load;

  // Pointer, count and output stage
  always_comb begin
    push = in_valid & ir_q;
    load = (~ov_q | out_ready) & (cnt_q != '0);
    wp_d = wp_q;
    rp_d = rp_q;
    if (push) begin
      wp_d = (wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1;
    end
    if (load) begin
      rp_d = (rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1;
    end
    cnt_d = cnt_q + (AW + 1)'(push) - (AW + 1)'(load);
    ov_d = load | (ov_q & ~out_ready);
    od_d = load ? mem[rp_q] : od_q;
    ir_d = cnt_d < (AW + 1)'(D);
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      ov_q <= 1'b0;
      od_q <= '0;
      ir_q <= 1'b0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      ov_q <= ov_d;
      od_q <= od_d;
      ir_q <= ir_d;
    end
  end

  // Storage array, no reset needed
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end

  assign in_ready = ir_q;
  assign out_valid = ov_q;
  assign out_data = od_q;
endmodule // slm_fifo

//--- test/slm_lane_mapper_asserts.sv
// Port checker for the lane mapper: bus handshake, drivers, stalls.
// Bound from tb_top; sees only top-level ports, one clock domain.
`timescale 1ns/1ps
module slm_lane_mapper_asserts import slm_pkg::*; (
  input logic core_clk, // Clock
  input logic reset_n, // Sync reset, low
  input logic [3:0] avs_address, // Byte address
  input logic avs_read, // Read strobe
  input logic avs_write, // Write strobe
  input logic [31:0] avs_readdata, // Read data
  input logic avs_waitrequest, // Stall
  input logic power_down_pin, // Power-down pin
  input logic lane_ready, // Link takes octets
  input slm_lanes_t lane_data, // Lane octets
  input logic lane_valid, // Octets valid
  input logic lane_bypass, // Raw output
  input logic [7:0] lane_drv_en // Driver enables
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  slm_lanes_t last_q;
  // Steps of one bus transfer
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  // Last octet set sent
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      last_q <= '0;
    end else if (lane_valid) begin
      last_q <= lane_data;
    end
  end
  // Bus and lane relations
  a_bus_one_wait: assert property (s_req |=> s_ack)
    else $error("bus answer not after one cycle");
  a_bus_idle_high: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("waitrequest low without request");
  a_unmapped_zero: assert property (avs_read && avs_waitrequest && avs_address == 4'hC
    |=> avs_readdata == 32'h0) else $error("unmapped read not zero");
  a_pd_drv_off: assert property (power_down_pin |=> lane_drv_en == 8'h00)
    else $error("drivers on in power-down");
  a_pd_no_adv: assert property (power_down_pin |=> !lane_valid)
    else $error("octets sent in power-down");
  a_bank_one_set: assert property (lane_drv_en inside {8'h00, 8'h0F, 8'hF0, 8'hFF})
    else $error("lane enables split a bank");
  a_valid_drv_on: assert property (lane_valid |-> lane_drv_en != 8'h00)
    else $error("octets sent with drivers off");
  a_stall_hold: assert property (!lane_ready |=> !lane_valid && $stable(lane_data))
    else $error("lanes moved while stalled");
  a_clk_fall: assert property (lane_valid && lane_bypass && last_q == {8{8'hFF}}
    |-> lane_data == '0) else $error("clock pattern did not fall");
endmodule // slm_lane_mapper_asserts

//--- test/slm_link_model.sv
// Link-layer model at the lane side: paces octets, reports link up.
// Assumes one clock shared with the mapper.
`timescale 1ns/1ps
module slm_link_model (
  input logic core_clk, // Clock
  input logic reset_n, // Sync reset, low
  input logic hold, // Stop taking octets
  input logic link_up, // Link allowed up
  input logic pd, // Device power-down
  output logic lane_ready, // Takes octets
  output logic link_ready // Alignment done
);
  // Random pacing; link drops in power-down and comes back after
  always @(posedge core_clk) begin
    if (!reset_n) begin
      lane_ready <= 1'h0;
      link_ready <= 1'h0;
    end else begin
      lane_ready <= !hold && ($urandom % 4 != 0);
      link_ready <= link_up && !pd;
    end
  end
endmodule // slm_link_model

//--- test/tb_top.sv
// Testbench for the lane mapper: registers, lane maps, power-down, patterns.
// Assumes slm_link_model at the lanes and the port checker bound below.
`timescale 1ns/1ps
`include "slm_consts.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value t=%0t got %0h exp %0h", $time, g, e); end end
module tb_top import slm_pkg::*;;
  logic core_clk = 1'h0, reset_n = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
  logic smp_valid = 1'h0, power_down_pin = 1'h0, hold = 1'h0, link_up = 1'h1;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  slm_word_t smp_data = '0;
  logic [31:0] avs_readdata, q, x;
  logic avs_waitrequest, smp_ready, lane_ready, link_ready, lane_valid, lane_bypass, sh_fec;
  logic [7:0] lane_drv_en;
  slm_lanes_t lane_data, d, e;
  logic [63:0] b0, b1;
  slm_word_t wq[$];
  int fail_count = 0;
  int checked = 0;
  int n;
  logic [3:0] tm[3] = '{`SLM_MODE_13, `SLM_MODE_14, `SLM_MODE_15};
  int fl[3] = '{5, 3, 3};
  int ta[5] = '{6, 5, 14, 18, 28};
  int tb[5] = '{7, 9, 15, 23, 31};
  slm_lane_mapper i_slm_lane_mapper (.core_clk, .reset_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .smp_valid, .smp_data, .smp_ready,
    .power_down_pin, .link_ready, .lane_ready, .lane_data, .lane_valid, .lane_bypass,
    .lane_drv_en, .sh_fec);
  slm_link_model i_slm_link_model (.core_clk, .reset_n, .hold, .link_up, .pd(power_down_pin),
    .lane_ready, .link_ready);
  // Clock, 8 ns period
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  // -----------------------------
  // Expectations and bus tasks
  // -----------------------------
  function automatic logic [31:0] cw(logic [3:0] m, logic bk, logic pd, logic [1:0] t,
    logic [2:0] ps, logic fec, logic sg);
    return {19'h0, sg, fec, ps, t, pd, bk, m};
  endfunction
  function automatic slm_word_t rnd();
    slm_word_t w;
    for (int i = 0; i < 9; i++) w[32*i +: 32] = $urandom;
    return w;
  endfunction
  function automatic logic [7:0] exp_oct(logic [3:0] m, slm_word_t w, int k, int j);
    logic [39:0] f;
    slm_smp_t [15:0] s;
    int i;
    f = '0;
    s = (k < 4) ? w.a : w.b;
    i = k % 4;
    if (m == `SLM_MODE_12) f[39:32] = s[i][8:1];
    if (m == `SLM_MODE_13) f = {s[i], 1'h0, s[i+4], 1'h0, s[i+8], 1'h0, s[i+12], 1'h0};
    if (m == `SLM_MODE_15) f[39:16] = {s[i], 3'h0, s[i+4], 3'h0};
    if (m == `SLM_MODE_14 && k < 4) begin
      s = (k < 2) ? w.a : w.b;
      f[39:16] = {s[k%2], 3'h0, s[k%2+2], 3'h0};
    end
    return f[39-8*j -: 8];
  endfunction
  task automatic results();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic to();
    fail_count++;
    $display("wrong value t=%0t wait ran out", $time);
    results();
  endtask
  task automatic bus(input bit w, input logic [3:0] a, input logic [31:0] dt,
    output logic [31:0] r);
    int c;
    c = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= dt;
    avs_write <= w;
    avs_read <= !w;
    do begin @(posedge core_clk); c++; end while (avs_waitrequest !== 1'h0 && c < 50);
    if (c >= 50) to();
    r = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] dt);
    bus(1, a, dt, x);
    repeat (2) @(posedge core_clk);
  endtask
  task automatic rd(input logic [3:0] a);
    bus(0, a, 32'h0, q);
  endtask
  task automatic push(input slm_word_t w);
    int c;
    c = 0;
    smp_valid <= 1'h1;
    smp_data <= w;
    do begin @(posedge core_clk); c++; end while (smp_ready !== 1'h1 && c < 300);
    if (c >= 300) to();
    smp_valid <= 1'h0;
  endtask
  task automatic get(output slm_lanes_t v);
    int c;
    c = 0;
    do begin @(posedge core_clk); c++; end while (lane_valid !== 1'h1 && c < 300);
    if (c >= 300) to();
    v = lane_data;
  endtask
  task automatic frame(input logic [3:0] m, input int f, input bit alt);
    slm_word_t w;
    w = rnd();
    push(w);
    for (int j = 0; j < f; j++) begin
      get(d);
      for (int k = alt ? 4 : 0; k < 8; k++)
        `CHK(d[k], exp_oct(m, w, alt ? k - 4 : k, j))
    end
  endtask
  // Main sequence
  initial begin
    void'($urandom(32'hB3D2));
    repeat (8) @(posedge core_clk);
    reset_n <= 1'h1;
    rd(`SLM_OFS_CTRL);
    `CHK(q, {19'h0, `SLM_CTRL_RST}) // reset value
    rd(`SLM_OFS_CHAN);
    `CHK(q, {30'h0, `SLM_CHAN_RST}) // reset value
    `CHK(lane_drv_en, 8'hFF)
    wr(4'hC, 32'hFFFFFFFF);
    rd(4'hC);
    `CHK(q, 32'h0) // unmapped place
    wr(`SLM_OFS_CHAN, 32'h0);
    rd(`SLM_OFS_CHAN);
    `CHK(q, {30'h0, `SLM_CHAN_RST})
    wr(`SLM_OFS_CHAN, 32'h1);
    `CHK(lane_drv_en, 8'h0F)
    wr(`SLM_OFS_CHAN, 32'h2);
    `CHK(lane_drv_en, 8'h0F)
    wr(`SLM_OFS_CHAN, 32'h3);
    wr(`SLM_OFS_CTRL, cw(4'h3, 0, 0, 0, 0, 0, 0));
    rd(`SLM_OFS_CTRL);
    `CHK(q[3:0], `SLM_MODE_12) // bad mode kept out
    hold <= 1'h1;
    repeat (4) @(posedge core_clk);
    smp_valid <= 1'h1;
    smp_data <= rnd();
    repeat (30) begin
      @(posedge core_clk);
      if (smp_ready === 1'h1) begin
        wq.push_back(smp_data);
        smp_data <= rnd();
      end
    end
    smp_valid <= 1'h0;
    `CHK(wq.size() inside {[8:10]}, 1'h1) // buffer full
    hold <= 1'h0;
    foreach (wq[i]) begin
      get(d);
      for (int k = 0; k < 8; k++) `CHK(d[k], exp_oct(`SLM_MODE_12, wq[i], k, 0))
    end
    repeat (20) @(posedge core_clk);
    `CHK(lane_valid, 1'h0)
    foreach (tm[i]) begin
      wr(`SLM_OFS_CTRL, cw(tm[i], 0, 0, `SLM_TM_NORM, 0, 0, 0));
      `CHK(lane_drv_en, (tm[i] == `SLM_MODE_14) ? 8'h0F : 8'hFF)
      frame(tm[i], fl[i], 0);
    end
    wr(`SLM_OFS_CTRL, cw(`SLM_MODE_15, 1, 0, `SLM_TM_NORM, 0, 0, 1));
    `CHK(lane_drv_en, 8'hF0)
    rd(`SLM_OFS_STAT);
    `CHK(q[2:1], 2'h3)
    frame(`SLM_MODE_15, 3, 1);
    wr(`SLM_OFS_CTRL, cw(`SLM_MODE_15, 1, 0, `SLM_TM_NORM, 0, 0, 0));
    `CHK(lane_drv_en, 8'hFF)
    power_down_pin <= 1'h1;
    repeat (3) @(posedge core_clk);
    `CHK(lane_drv_en, 8'h00)
    rd(`SLM_OFS_CTRL);
    `CHK(q, cw(`SLM_MODE_15, 1, 0, `SLM_TM_NORM, 0, 0, 0))
    power_down_pin <= 1'h0;
    repeat (3) @(posedge core_clk);
    `CHK(lane_drv_en, 8'hFF)
    wr(`SLM_OFS_CTRL, cw(`SLM_MODE_15, 1, 1, `SLM_TM_NORM, 0, 0, 0));
    `CHK(lane_drv_en, 8'h00)
    rd(`SLM_OFS_STAT);
    `CHK(q[0], 1'h1)
    wr(`SLM_OFS_CTRL, cw(`SLM_MODE_12, 0, 0, `SLM_TM_NORM, 0, 1, 0));
    `CHK(sh_fec, 1'h1)
    for (int p = 0; p < 5; p++) begin
      wr(`SLM_OFS_CTRL, cw(`SLM_MODE_12, 0, 0, `SLM_TM_NORM, 0, 0, 0));
      `CHK(sh_fec, 1'h0)
      wr(`SLM_OFS_CTRL, cw(`SLM_MODE_12, 0, 0, `SLM_TM_PRBS, 3'(p), 0, 0));
      get(d);
      for (int j = 0; j < 8; j++) begin
        get(d);
        b0 = {b0[55:0], d[0]};
        b1 = {b1[55:0], d[1]};
      end
      `CHK(lane_bypass, 1'h1)
      for (int i = tb[p]; i < 64; i++) `CHK(b0[63-i], b0[63-i+ta[p]] ^ b0[63-i+tb[p]])
      `CHK(b0 != b1, 1'h1)
    end
    wr(`SLM_OFS_CTRL, cw(`SLM_MODE_12, 0, 0, `SLM_TM_CLK, 0, 0, 0));
    get(e);
    get(e);
    get(d);
    `CHK(d, ~e)
    `CHK(d, {8{d[0]}})
    `CHK(d[0] == 8'hFF || d[0] == 8'h00, 1'h1)
    `CHK(lane_bypass, 1'h1)
    link_up <= 1'h0;
    wr(`SLM_OFS_CTRL, cw(`SLM_MODE_12, 0, 0, `SLM_TM_RAMP, 0, 0, 0));
    n = 0;
    repeat (20) begin
      @(posedge core_clk);
      n += (lane_valid === 1'h1);
    end
    `CHK(n, 0)
    push(rnd());
    link_up <= 1'h1;
    for (int i = 0; i < 260; i++) begin
      get(d);
      `CHK(d, {8{8'(i)}})
    end
    `CHK(lane_bypass, 1'h0)
    rd(`SLM_OFS_STAT);
    `CHK(q[3], 1'h1)
    results();
  end
endmodule // tb_top
bind slm_lane_mapper slm_lane_mapper_asserts i_slm_lane_mapper_asserts (.core_clk, .reset_n,
  .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .power_down_pin,
  .lane_ready, .lane_data, .lane_valid, .lane_bypass, .lane_drv_en);
